// File: core/led_drive_pkg.sv
// constants for the led drive current configuration registers
package led_drive_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] led1_drive_control_addr = 8'h23;
	localparam logic [7:0] led2_drive_control_addr = 8'h24;
	localparam logic [7:0] fine_adjust_addr = 8'h25;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int strength_bit = 13;
	localparam int edge_rate_lsb = 4;
	localparam int coarse_lsb = 0;
	localparam int drv1_fine_lsb = 0;
	localparam int drv2_fine_lsb = 6;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] drive_control_reset = 16'h3000;
	localparam logic [15:0] fine_adjust_reset = 16'h630c;
	// ----------------------------------------
	// peak target fixed point (milliamp times 1000 factors)
	// ----------------------------------------
	localparam logic [31:0] coarse_base = 32'h0000_6d60;
	localparam logic [31:0] coarse_step = 32'h0000_3c64;
	localparam logic [31:0] fine_base = 32'h0000_02c6;
	localparam logic [31:0] fine_step = 32'h0000_0018;
	localparam logic [31:0] scale_low = 32'h0000_0190;
	localparam logic [31:0] scale_full = 32'h0000_03e8;
endpackage : led_drive_pkg

// File: core/led_drive_current_config.sv
// led driver current configuration register bank
// Behaviour
// - driver one coarse code resets zero; code n targets 28 to 259 mA.
// - driver one peak target is coarse times fine times scale factor.
// - driver two strength bit resets one; zero means 40% low power.
// - driver two edge rate resets zero; 0 slowest, 7 fastest.
// - driver two coarse code like driver one; fine from shared bits 10:6.
// - driver two bits 15:14 and 11:7 reset zero, bit 12 resets one.
// - driver one strength bit resets one; zero means 40% low power.
`timescale 1ns/1ps
`default_nettype none
module led_drive_current_config
	import led_drive_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] fine_adjust,
	output logic [15:0] reg_rdata,
	output logic drv1_strength_select,
	output logic [2:0] drv1_edge_rate,
	output logic [3:0] drv1_coarse_code,
	output logic [31:0] drv1_peak_target,
	output logic drv2_strength_select,
	output logic [2:0] drv2_edge_rate,
	output logic [3:0] drv2_coarse_code,
	output logic [31:0] drv2_peak_target
);
	// ----------------------------------------
	// storage and decode
	// ----------------------------------------
	logic [15:0] led1_drive_control;
	logic [15:0] led2_drive_control;
	wire logic wr1 = reg_wr && (reg_addr == led1_drive_control_addr);
	wire logic wr2 = reg_wr && (reg_addr == led2_drive_control_addr);
	wire logic [15:0] next_led1 = wr1 ? reg_wdata : led1_drive_control;
	wire logic [15:0] next_led2 = wr2 ? reg_wdata : led2_drive_control;
	wire logic [15:0] next_rdata =
		(reg_addr == led1_drive_control_addr) ? next_led1 :
		(reg_addr == led2_drive_control_addr) ? next_led2 : 16'h0000;

	// peak target in microamps (factors scaled by 1000)
	function automatic logic [31:0] peak(input logic [3:0] c,
		input logic [4:0] f, input logic s);
		logic [63:0] p;
		p = 64'((coarse_base + coarse_step * 32'(c)) / 32'd1000)
			* 64'(fine_base + fine_step * 32'(f))
			* 64'(s ? scale_full : scale_low);
		peak = 32'(p / 64'd1000);
	endfunction : peak

	wire logic [31:0] next_peak1 = peak(next_led1[coarse_lsb +: 4],
		fine_adjust[drv1_fine_lsb +: 5], next_led1[strength_bit]);
	wire logic [31:0] next_peak2 = peak(next_led2[coarse_lsb +: 4],
		fine_adjust[drv2_fine_lsb +: 5], next_led2[strength_bit]);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			led1_drive_control <= drive_control_reset;
			led2_drive_control <= drive_control_reset;
			reg_rdata <= 16'h0000;
		end else begin
			led1_drive_control <= next_led1;
			led2_drive_control <= next_led2;
			reg_rdata <= next_rdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drv1_strength_select <= 1'b1;
			drv1_edge_rate <= 3'h0;
			drv1_coarse_code <= 4'h0;
			drv2_strength_select <= 1'b1;
			drv2_edge_rate <= 3'h0;
			drv2_coarse_code <= 4'h0;
			drv1_peak_target <= 32'h0000_0000;
			drv2_peak_target <= 32'h0000_0000;
		end else begin
			drv1_strength_select <= next_led1[strength_bit];
			drv1_edge_rate <= next_led1[edge_rate_lsb +: 3];
			drv1_coarse_code <= next_led1[coarse_lsb +: 4];
			drv2_strength_select <= next_led2[strength_bit];
			drv2_edge_rate <= next_led2[edge_rate_lsb +: 3];
			drv2_coarse_code <= next_led2[coarse_lsb +: 4];
			drv1_peak_target <= next_peak1;
			drv2_peak_target <= next_peak2;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	reset_one_a: assert property (disable iff (1'b0)
		rst && $past(rst) |->
		led1_drive_control == drive_control_reset)
		else $error("control one reset value wrong");

	reset_two_a: assert property (disable iff (1'b0)
		rst && $past(rst) |->
		led2_drive_control == drive_control_reset)
		else $error("control two reset value wrong");

	reset_fields_a: assert property (disable iff (1'b0)
		rst && $past(rst) |->
		drv1_strength_select && drv2_strength_select
		&& drv1_edge_rate == 3'h0 && drv2_edge_rate == 3'h0
		&& drv1_coarse_code == 4'h0 && drv2_coarse_code == 4'h0)
		else $error("field outputs not at reset values");

	reset_rdata_a: assert property (disable iff (1'b0)
		rst && $past(rst) |-> reg_rdata == 16'h0000
		&& drv1_peak_target == 32'h0000_0000
		&& drv2_peak_target == 32'h0000_0000)
		else $error("read data or peak targets not cleared");

	// ----------------------------------------
	// writes land in the addressed word only
	// ----------------------------------------
	write_one_a: assert property (wr1 |=>
		drv1_coarse_code == $past(reg_wdata[3:0]))
		else $error("coarse one not taken");

	edge_one_a: assert property (wr1 |=>
		drv1_edge_rate == $past(reg_wdata[6:4]))
		else $error("edge rate one not taken");

	strength_one_a: assert property (wr1 |=>
		drv1_strength_select == $past(reg_wdata[13]))
		else $error("strength one wrong");

	stored_one_a: assert property (wr1 |=>
		led1_drive_control == $past(reg_wdata))
		else $error("control one not stored");

	write_two_a: assert property (wr2 |=>
		drv2_edge_rate == $past(reg_wdata[6:4]))
		else $error("edge rate not taken");

	coarse_two_a: assert property (wr2 |=>
		drv2_coarse_code == $past(reg_wdata[3:0]))
		else $error("coarse two not taken");

	strength_two_a: assert property (wr2 |=>
		drv2_strength_select == $past(reg_wdata[13]))
		else $error("strength two wrong");

	reserved_two_a: assert property (wr2 |=>
		led2_drive_control[15:7] == $past(reg_wdata[15:7]))
		else $error("reserved not kept");

	write_ignored_a: assert property (reg_wr && !wr1 && !wr2 |=>
		$stable(led1_drive_control) && $stable(led2_drive_control))
		else $error("unmapped write changed a control word");

	// ----------------------------------------
	// fields hold until overwritten
	// ----------------------------------------
	hold_one_a: assert property (!wr1 |=>
		$stable(led1_drive_control))
		else $error("control one changed");

	hold_two_a: assert property (!wr2 |=>
		$stable(led2_drive_control))
		else $error("control two changed");

	hold_fields_one_a: assert property (!wr1 |=>
		$stable(drv1_strength_select) && $stable(drv1_edge_rate)
		&& $stable(drv1_coarse_code))
		else $error("driver one fields changed");

	hold_fields_two_a: assert property (!wr2 |=>
		$stable(drv2_strength_select) && $stable(drv2_edge_rate)
		&& $stable(drv2_coarse_code))
		else $error("driver two fields changed");

	// ----------------------------------------
	// read back
	// ----------------------------------------
	readback_a: assert property (wr2 ##1 (!reg_wr
		&& reg_addr == led2_drive_control_addr) |=>
		reg_rdata == $past(reg_wdata, 2))
		else $error("readback wrong");

	read_one_a: assert property (!reg_wr
		&& reg_addr == led1_drive_control_addr |=>
		reg_rdata == $past(led1_drive_control))
		else $error("read of control one wrong");

	read_two_a: assert property (!reg_wr
		&& reg_addr == led2_drive_control_addr |=>
		reg_rdata == $past(led2_drive_control))
		else $error("read of control two wrong");

	unmapped_read_a: assert property (
		reg_addr != led1_drive_control_addr
		&& reg_addr != led2_drive_control_addr |=>
		reg_rdata == 16'h0000)
		else $error("unmapped read not zero");

	// ----------------------------------------
	// peak targets
	// ----------------------------------------
	peak_max_a: assert property (wr1 && reg_wdata[13]
		&& &reg_wdata[3:0] && fine_adjust[4:0] == 5'h0c |=>
		drv1_peak_target == 32'h0003_f1b2)
		else $error("peak one wrong");

	peak_low_a: assert property (wr2 && !reg_wdata[13]
		&& reg_wdata[3:0] == 4'h0 && fine_adjust[10:6] == 5'h00 |=>
		drv2_peak_target == 32'h0000_1f10)
		else $error("peak two wrong");

	floor_one_a: assert property (!$past(rst) |->
		drv1_peak_target >= (drv1_strength_select
		? 32'h0000_4da8 : 32'h0000_1f10))
		else $error("peak one below its floor");

	ceiling_one_a: assert property (drv1_peak_target
		<= (drv1_strength_select ? 32'h0005_bf0a : 32'h0002_4c6a))
		else $error("peak one above its ceiling");

	floor_two_a: assert property (!$past(rst) |->
		drv2_peak_target >= (drv2_strength_select
		? 32'h0000_4da8 : 32'h0000_1f10))
		else $error("peak two below its floor");

	ceiling_two_a: assert property (drv2_peak_target
		<= (drv2_strength_select ? 32'h0005_bf0a : 32'h0002_4c6a))
		else $error("peak two above its ceiling");

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	write_one_c: cover property (wr1);
	write_two_c: cover property (wr2);
	low_power_c: cover property (wr2 && !reg_wdata[13]);
	back_to_back_c: cover property (wr1 ##1 wr2);
	full_scale_c: cover property (wr1 && reg_wdata[13] && &reg_wdata[3:0]);
endmodule : led_drive_current_config
`default_nettype wire

// File: bench/led_drive_current_config_test.sv
// self-checking bench for the led drive current configuration bank
`timescale 1ns/1ps
`default_nettype none
module led_drive_current_config_test;
	import led_drive_pkg::*;
	logic clk, rst, reg_wr, drv1_strength_select, drv2_strength_select;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, fine_adjust, reg_rdata;
	logic [2:0] drv1_edge_rate, drv2_edge_rate;
	logic [3:0] drv1_coarse_code, drv2_coarse_code;
	logic [31:0] drv1_peak_target, drv2_peak_target;
	int mismatches, checks_done;
	led_drive_current_config u_dut (.clk, .rst, .reg_wr, .reg_addr,
		.reg_wdata, .fine_adjust, .reg_rdata, .drv1_strength_select,
		.drv1_edge_rate, .drv1_coarse_code, .drv1_peak_target,
		.drv2_strength_select, .drv2_edge_rate, .drv2_coarse_code,
		.drv2_peak_target);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] peak(input int c, input int f, input int s);
		return (28000 + 15460 * c) / 1000 * (710 + 24 * f)
			* (s ? 1000 : 400) / 1000;
	endfunction : peak
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = a;
		@(negedge clk);
		chk("reg_rdata", {16'h0000, e}, {16'h0000, reg_rdata});
	endtask : rd
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{rst, reg_wr, reg_addr, reg_wdata} = {1'b1, 25'h0};
		fine_adjust = fine_adjust_reset;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		rd(8'h23, 16'h3000);
		rd(8'h24, 16'h3000);
		chk("strength", 32'h3, {drv1_strength_select, drv2_strength_select});
		chk("codes", 32'h0, {drv1_edge_rate, drv1_coarse_code, drv2_coarse_code});
		chk("edge2", 32'h0, drv2_edge_rate);
		chk("peak1", peak(0, 12, 1), drv1_peak_target);
		$display("reset test done");
		fine_adjust = 16'h000c;
		wr(8'h23, 16'h300f);
		wr(8'h24, 16'h1000);
		rd(8'h24, 16'h1000);
		chk("strength2", 32'h0, drv2_strength_select);
		chk("coarse1", 32'hf, drv1_coarse_code);
		chk("peak1", 32'h0003_f1b2, drv1_peak_target);
		chk("peak2", 32'h0000_1f10, drv2_peak_target);
		$display("limit test done");
		wr(8'h24, 16'h2075);
		wr(8'h23, 16'h0fa3);
		rd(8'h24, 16'h2075);
		rd(8'h23, 16'h0fa3);
		chk("drv2", 32'hf5, {drv2_strength_select, drv2_edge_rate, drv2_coarse_code});
		chk("drv1", 32'h23, {drv1_strength_select, drv1_edge_rate, drv1_coarse_code});
		fine_adjust = 16'h07c1;
		rd(8'h25, 16'h0000);
		chk("peak1", peak(3, 1, 0), drv1_peak_target);
		chk("peak2", peak(5, 31, 1), drv2_peak_target);
		wr(8'h25, 16'hffff);
		wr(8'h22, 16'hffff);
		rd(8'h22, 16'h0000);
		rd(8'h23, 16'h0fa3);
		$display("write test done");
		for (int i = 0; i < 16; i++) begin
			wr(8'h24, 16'h3000 | 16'(i % 8) << 4 | 16'(i));
			rd(8'h24, 16'h3000 | 16'(i % 8) << 4 | 16'(i));
			chk("edge2", 32'(i % 8), drv2_edge_rate);
			chk("coarse2", 32'(i), drv2_coarse_code);
			chk("peak2", peak(i, 31, 1), drv2_peak_target);
		end
		$display("code test done");
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		rd(8'h24, 16'h3000);
		rd(8'h23, 16'h3000);
		chk("strength1", 32'h1, drv1_strength_select);
		chk("coarse1", 32'h0, drv1_coarse_code);
		chk("peak1", peak(0, 1, 1), drv1_peak_target);
		$display("second reset test done");
		results();
	end
endmodule : led_drive_current_config_test
`default_nettype wire
